// [inc/pbt_params.svh]
// Constants of the programmable binary timer: APB offsets, control fields,
// reset values and oscillator timing. Included by the package and the RTL.
// Assumes a 25 MHz pclk and a 12-bit byte address on APB.
//
// Functional notes
// R1 - Sixteen-stage binary counter driven by oscillator
// R2 - Counter advances only on rising clock edges
// R3 - Power-up reset unless auto reset disabled
// R4 - Master reset high holds counter reset
// R5 - Any reset clears all stages together
// R6 - Master reset independent of auto reset
// R7 - Oscillator stopped while any reset active
// R8 - Selects give stages 13, 10, 8, 16
// R9 - Select A high routes sixteenth stage
// R10 - A=1, B=0 clocks ninth stage directly
// R11 - In reset output follows polarity select
// R12 - Recycle mode passes selected stage continuously
// R13 - Single mode latch sets after 2^(n-1)
// R14 - Single mode holds until reset or mode change
// R15 - External clock may replace internal oscillator
// R16 - Power-up input and divided clock oscillator
`ifndef PBT_PARAMS_SVH
`define PBT_PARAMS_SVH

// Register byte offsets
`define PBT_ADDR_W 12
`define PBT_OFF_CTRL 12'h000
`define PBT_OFF_OSC_DIV 12'h004
`define PBT_OFF_STATUS 12'h008

// Control word fields
`define PBT_CTRL_AUTO_OFF 0
`define PBT_CTRL_MASTER_RESET 1
`define PBT_CTRL_SEL_A 2
`define PBT_CTRL_SEL_B 3
`define PBT_CTRL_POLARITY 4
`define PBT_CTRL_RECYCLE 5
`define PBT_CTRL_EXT_CLK 6
`define PBT_CTRL_RESET 7'h00

// Status word fields
`define PBT_STAT_IN_RESET 16
`define PBT_STAT_LATCH 17
`define PBT_STAT_OUT 18

// Oscillator: one count per (divisor + 1) pclk cycles
`define PBT_OSC_DIV_RESET 16'h0018

`endif

// [inc/pbt_pkg.sv]
// Types of the programmable binary timer.
// Assumes pbt_params.svh sits on the include path.
`include "pbt_params.svh"

package pbt_pkg;

  // Control register contents
  typedef struct packed {
    logic ext_clk_sel;
    logic recycle;
    logic polarity;
    logic sel_b;
    logic sel_a;
    logic master_reset;
    logic auto_off;
  } pbt_ctrl_s;

  typedef logic [15:0] pbt_count_t;

endpackage

// [rtl/pbt_timer.sv]
// Programmable binary timer with an APB register slave.
// Assumes the package compiled first, pclk at 25 MHz and all pins synchronous.
`timescale 1ns/1ns
`include "pbt_params.svh"

module pbt_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PBT_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_up,
  input wire logic ext_clk,
  output logic timer_q
);

  pbt_pkg::pbt_ctrl_s ctrl;
  pbt_pkg::pbt_ctrl_s next_ctrl;
  logic [15:0] osc_div;
  logic [15:0] next_osc_div;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [15:0] osc_cnt;
  logic [15:0] next_osc_cnt;
  logic ext_prev;
  pbt_pkg::pbt_count_t cnt;
  pbt_pkg::pbt_count_t next_cnt;
  logic latch;
  logic next_latch;
  logic mode_prev;
  logic next_timer_q;
  logic in_reset;
  logic tick;
  logic bypass;
  logic stage;
  logic mode_chg;
  logic wr_take;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Reset sources; master reset acts whatever auto reset says
  assign in_reset = ctrl.master_reset | (power_up & ~ctrl.auto_off); // [R3] [R4] [R6]

  // Count source: divided pclk or external clock rising edge, frozen in reset
  always_comb begin
    next_osc_cnt = osc_cnt + 16'h0001;
    if (in_reset || osc_cnt >= osc_div) begin
      next_osc_cnt = 16'h0000; // [R7]
    end
  end
  assign tick = ~in_reset & (ctrl.ext_clk_sel ? (ext_clk & ~ext_prev) // [R15] [R2]
                                              : (osc_cnt >= osc_div)); // [R16] [R7]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_cnt <= 16'h0000;
      ext_prev <= 1'b0;
    end else begin
      osc_cnt <= next_osc_cnt;
      ext_prev <= ext_clk;
    end
  end

  // Stage select: A high always means the last stage
  assign bypass = ctrl.sel_a & ~ctrl.sel_b; // [R10]
  always_comb begin
    if (ctrl.sel_a) begin
      stage = cnt[15]; // [R9] [R8]
    end else if (ctrl.sel_b) begin
      stage = cnt[9]; // [R8]
    end else begin
      stage = cnt[12]; // [R8]
    end
  end
  assign mode_chg = ctrl.recycle ^ mode_prev; // [R14]

  // Counter chain; in bypass the low eight stages sit idle
  always_comb begin
    next_cnt = cnt;
    if (in_reset || mode_chg) begin
      next_cnt = 16'h0000; // [R5]
    end else if (tick && bypass) begin
      next_cnt[15:8] = cnt[15:8] + 8'h01; // [R10]
    end else if (tick) begin
      next_cnt = cnt + 16'h0001; // [R1] [R2]
    end
  end

  // Single-cycle latch and output; the latch only clears on restart
  always_comb begin
    next_latch = latch | (~ctrl.recycle & stage); // [R13] [R14]
    if (in_reset || mode_chg) begin
      next_latch = 1'b0; // [R13]
    end
    if (in_reset) begin
      next_timer_q = ctrl.polarity; // [R11]
    end else if (ctrl.recycle) begin
      next_timer_q = stage ^ ctrl.polarity; // [R12]
    end else begin
      next_timer_q = latch ^ ctrl.polarity; // [R13]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 16'h0000;
      latch <= 1'b0;
      mode_prev <= 1'b0;
      timer_q <= 1'b0;
    end else begin
      cnt <= next_cnt;
      latch <= next_latch;
      mode_prev <= ctrl.recycle;
      timer_q <= next_timer_q;
    end
  end

  // APB slave: one wait state so read data and error come from flops
  assign wr_take = psel & penable & pready & pwrite;
  always_comb begin
    next_ctrl = ctrl;
    next_osc_div = osc_div;
    next_pready = psel & penable & ~pready;
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (wr_take && paddr == `PBT_OFF_CTRL) begin
      next_ctrl.auto_off = pwdata[`PBT_CTRL_AUTO_OFF];
      next_ctrl.master_reset = pwdata[`PBT_CTRL_MASTER_RESET];
      next_ctrl.sel_a = pwdata[`PBT_CTRL_SEL_A];
      next_ctrl.sel_b = pwdata[`PBT_CTRL_SEL_B];
      next_ctrl.polarity = pwdata[`PBT_CTRL_POLARITY];
      next_ctrl.recycle = pwdata[`PBT_CTRL_RECYCLE];
      next_ctrl.ext_clk_sel = pwdata[`PBT_CTRL_EXT_CLK];
    end
    if (wr_take && paddr == `PBT_OFF_OSC_DIV) begin
      next_osc_div = pwdata[15:0];
    end
    if (next_pready) begin
      case (paddr)
        `PBT_OFF_CTRL: begin
          next_prdata[6:0] = ctrl;
        end
        `PBT_OFF_OSC_DIV: begin
          next_prdata[15:0] = osc_div;
        end
        `PBT_OFF_STATUS: begin
          next_prdata[15:0] = cnt;
          next_prdata[`PBT_STAT_IN_RESET] = in_reset;
          next_prdata[`PBT_STAT_LATCH] = latch;
          next_prdata[`PBT_STAT_OUT] = timer_q;
          next_pslverr = pwrite; // Status is read only
        end
        default: begin
          next_pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= pbt_pkg::pbt_ctrl_s'(`PBT_CTRL_RESET);
      osc_div <= `PBT_OSC_DIV_RESET;
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      osc_div <= next_osc_div;
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Checks
  sequence s_count_run;
    !in_reset && !mode_chg && tick;
  endsequence

  sequence s_hold_idle;
    !in_reset && !mode_chg && !tick;
  endsequence

  // Either reset or a mode flip restarts the single-cycle run
  sequence s_restart;
    in_reset || mode_chg;
  endsequence

  // Access cycle still waiting for its answer
  sequence s_apb_wait;
    psel && penable && !pready;
  endsequence

  chk_reset_clears: assert property (in_reset |=> cnt == 16'h0000) // [R5] [R4]
    else $error("counter not cleared by reset");

  chk_osc_stopped: assert property (in_reset |-> !tick) // [R7]
    else $error("count source active in reset");

  chk_count_step: assert property (s_count_run ##0 !bypass |=> cnt == $past(cnt) + 16'h0001) // [R1] [R2]
    else $error("counter did not advance by one");

  chk_idle_hold: assert property (s_hold_idle |=> $stable(cnt)) // [R2]
    else $error("counter moved without a count");

  chk_bypass_low: assert property (s_count_run ##0 bypass |=> cnt[7:0] == $past(cnt[7:0])
                                   && cnt[15:8] == $past(cnt[15:8]) + 8'h01) // [R10]
    else $error("bypass did not clock upper stages");

  chk_sel_top: assert property (ctrl.sel_a |-> stage == cnt[15]) // [R9]
    else $error("select A high did not pick last stage");

  chk_sel_mid: assert property (!ctrl.sel_a |-> stage == (ctrl.sel_b ? cnt[9] : cnt[12])) // [R8]
    else $error("wrong stage selected");

  chk_reset_level: assert property (in_reset |=> timer_q == $past(ctrl.polarity)) // [R11]
    else $error("output not at polarity level in reset");

  chk_recycle_out: assert property (!in_reset && ctrl.recycle |=> timer_q == $past(stage ^ ctrl.polarity)) // [R12]
    else $error("recycle output not following stage");

  chk_latch_set: assert property (!in_reset && !mode_chg && !ctrl.recycle && stage |=> latch) // [R13]
    else $error("single cycle latch failed to set");

  chk_latch_hold: assert property (latch && !in_reset && !mode_chg |=> latch) // [R14]
    else $error("single cycle latch dropped");

  chk_auto_off: assert property (ctrl.auto_off && !ctrl.master_reset |-> !in_reset) // [R3] [R6]
    else $error("power-up reset acted while disabled");

  chk_master_rst: assert property (ctrl.master_reset |-> in_reset) // [R4] [R6]
    else $error("master reset not honoured");

  chk_apb_wait: assert property (s_apb_wait |=> pready ##1 !pready)
    else $error("APB answer not one wait state");

  // Restart and oscillator freeze
  chk_restart_clear: assert property (s_restart |=> !latch && cnt == 16'h0000) // [R13] [R5]
    else $error("restart left latch or count");

  chk_mode_restart: assert property (mode_chg |=> cnt == 16'h0000) // [R14]
    else $error("mode change did not restart the chain");

  chk_osc_hold: assert property (in_reset |=> osc_cnt == 16'h0000) // [R7]
    else $error("oscillator ran during reset");

  chk_power_rst: assert property (power_up && !ctrl.auto_off |-> in_reset) // [R3]
    else $error("power-up request ignored");

  // Divided oscillator steps up to the divisor, then wraps;
  // a divisor written below the running count wraps at once
  chk_osc_step: assert property (!in_reset && osc_cnt < osc_div |=> osc_cnt == $past(osc_cnt) + 16'h0001) // [R16]
    else $error("oscillator divider did not step");

  chk_osc_wrap: assert property (!in_reset && osc_cnt >= osc_div |=> osc_cnt == 16'h0000) // [R16]
    else $error("oscillator divider did not wrap");

  chk_ext_edge: assert property (!in_reset && ctrl.ext_clk_sel |-> tick == (ext_clk && !ext_prev)) // [R15] [R2]
    else $error("external clock edge not counted once");

  chk_bypass_idle: assert property (bypass && !in_reset && !mode_chg |=> $stable(cnt[7:0])) // [R10]
    else $error("low stages moved in bypass");

  // Single-cycle output follows the latch;
  // recycle keeps the latch clear so a later switch starts clean
  chk_single_out: assert property (!in_reset && !ctrl.recycle |=> timer_q == $past(latch ^ ctrl.polarity)) // [R13]
    else $error("single cycle output not following latch");

  chk_single_stay: assert property (latch && !in_reset && !ctrl.recycle |=> timer_q != $past(ctrl.polarity)) // [R14]
    else $error("single cycle output changed back");

  chk_latch_recycle: assert property (ctrl.recycle && !mode_chg |-> !latch) // [R12]
    else $error("latch set in recycle mode");

  // APB answers: data and error only with ready, writes land at the ready edge
  chk_apb_idle: assert property (!pready |-> prdata == 32'h0000_0000 && !pslverr)
    else $error("read data or error outside the answer cycle");

  chk_ctrl_write: assert property (wr_take && paddr == `PBT_OFF_CTRL |=> ctrl == $past(pwdata[6:0]))
    else $error("control write did not land");

  chk_div_write: assert property (wr_take && paddr == `PBT_OFF_OSC_DIV |=> osc_div == $past(pwdata[15:0])) // [R16]
    else $error("divisor write did not land");

  chk_status_ro: assert property (wr_take && paddr == `PBT_OFF_STATUS |=> $stable(ctrl) && $stable(osc_div))
    else $error("status write changed a register");

  chk_err_status: assert property (s_apb_wait ##0 (pwrite && paddr == `PBT_OFF_STATUS) |=> pslverr)
    else $error("status write not refused");

  chk_unmapped_err: assert property (s_apb_wait ##0 (paddr > `PBT_OFF_STATUS) |=> pslverr)
    else $error("unmapped address not refused");

  chk_ctrl_ok: assert property (s_apb_wait ##0 (paddr == `PBT_OFF_CTRL) |=> !pslverr)
    else $error("control access refused");

  chk_div_read: assert property (s_apb_wait ##0 paddr == `PBT_OFF_OSC_DIV |=> prdata == {16'h0000, $past(osc_div)})
    else $error("divisor read back wrong");

endmodule

// [tb/pbt_sys_model.sv]
// Model of the system logic that drives the timer's count clock and power-up pin.
// Assumes pclk from the bench; pins change only just after rising edges.
`timescale 1ns/1ns
module pbt_sys_model (
  input wire logic pclk,
  output logic ext_clk,
  output logic power_up
);
  initial begin
    ext_clk = 1'b0;
    power_up = 1'b0;
  end

  // Two pclk high and at least two low, so the design's edge sampler never misses one
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge pclk) ext_clk <= 1'b1;
      repeat (2) @(posedge pclk);
      ext_clk <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask

  // Level request for power-on initialisation
  task automatic set_power(input logic v);
    @(posedge pclk) power_up <= v;
  endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench of the programmable binary timer over APB.
// Assumes pbt_params.svh on the include path and the system model beside it.
`timescale 1ns/1ns
`include "pbt_params.svh"
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_clk, power_up, timer_q, err_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q, seed;
  int mismatches, num_checks, cycles, n, h;
  logic a, b, rec;

  pbt_timer pbt_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_up(power_up), .ext_clk(ext_clk), .timer_q(timer_q));
  pbt_sys_model pbt_sys_model_i (.pclk(pclk), .ext_clk(ext_clk), .power_up(power_up));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Hang guard, well above the longest pulse train
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      stop_test();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Counts until the selected stage first goes high
  function automatic int half(input logic sa, input logic sb);
    return sa ? (sb ? 32768 : 128) : (sb ? 512 : 4096);
  endfunction
  // Bypass feeds stage nine, so the low byte never moves
  function automatic logic [31:0] cnt_of(input logic sa, input logic sb, input int k);
    return {16'h0000, (sa & !sb) ? 16'(k << 8) : 16'(k)};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; waits for pready however long it takes
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d = 32'h0);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    seed = 32'h86b99441;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `PBT_OFF_CTRL);
    chk("ctrl reset", 32'h0, rd_q);
    chk("ctrl err", 32'h0, err_q);
    apb(0, `PBT_OFF_OSC_DIV);
    chk("div reset", {16'h0000, `PBT_OSC_DIV_RESET}, rd_q);
    chk("q reset", 32'h0, timer_q);
    apb(0, 12'h00c);
    chk("unmapped err", 32'h1, err_q);
    chk("unmapped data", 32'h0, rd_q);
    apb(1, `PBT_OFF_STATUS, 32'hffffffff);
    chk("status write err", 32'h1, err_q);
    $display("test registers done");
    pbt_sys_model_i.set_power(1'b1);
    apb(0, `PBT_OFF_STATUS);
    chk("power up reset", 32'h1, rd_q[16]);
    apb(1, `PBT_OFF_CTRL, 32'h01);
    apb(0, `PBT_OFF_STATUS);
    chk("auto off", 32'h0, rd_q[16]);
    apb(1, `PBT_OFF_CTRL, 32'h03);
    apb(0, `PBT_OFF_STATUS);
    chk("master alone", 32'h1, rd_q[16]);
    pbt_sys_model_i.set_power(1'b0);
    apb(1, `PBT_OFF_CTRL, 32'h12);
    repeat (50) @(posedge pclk);
    chk("q polarity", 32'h1, timer_q);
    apb(0, `PBT_OFF_STATUS);
    chk("held count", 32'h0, rd_q[15:0]);
    $display("test resets done");
    seed = lfsr(seed);
    apb(1, `PBT_OFF_OSC_DIV, {16'h0000, seed[31:16]});
    apb(0, `PBT_OFF_OSC_DIV);
    chk("div rw", {16'h0000, seed[31:16]}, rd_q);
    n = int'(seed[5:0]) + 1;
    apb(1, `PBT_OFF_CTRL, 32'h48);
    pbt_sys_model_i.pulse(n);
    repeat (4) @(posedge pclk);
    apb(0, `PBT_OFF_STATUS);
    chk("edge count", cnt_of(0, 1, n), rd_q[15:0]);
    $display("test random count done");
    // Bypass recycle, then single cycle; each mode change restarts the chain
    for (int i = 0; i < 2; i++) begin
      a = (i == 0);
      b = (i == 1);
      rec = (i == 0);
      h = half(a, b);
      apb(1, `PBT_OFF_CTRL, {25'h0, 1'b1, rec, 1'b0, b, a, 2'b00});
      pbt_sys_model_i.pulse(h - 1);
      repeat (4) @(posedge pclk);
      chk("q before", 32'h0, timer_q);
      pbt_sys_model_i.pulse(1);
      repeat (4) @(posedge pclk);
      chk("q after", 32'h1, timer_q);
      pbt_sys_model_i.pulse(h);
      repeat (4) @(posedge pclk);
      chk("q second", {31'h0, !rec}, timer_q);
      apb(0, `PBT_OFF_STATUS);
      chk("chain count", cnt_of(a, b, 2 * h), rd_q[15:0]);
      $display("test stage %0d done", i);
    end
    // Master reset pulse restarts a finished single cycle
    apb(1, `PBT_OFF_CTRL, 32'h4a);
    apb(0, `PBT_OFF_STATUS);
    chk("restart status", 32'h1, rd_q[18:16]);
    apb(1, `PBT_OFF_CTRL, 32'h48);
    pbt_sys_model_i.pulse(512);
    repeat (4) @(posedge pclk);
    chk("restart q", 32'h1, timer_q);
    $display("test restart done");
    // Bus reset in mid-run returns every register to its reset value
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk("q bus reset", 32'h0, timer_q);
    apb(0, `PBT_OFF_CTRL);
    chk("ctrl bus reset", 32'h0, rd_q);
    apb(0, `PBT_OFF_OSC_DIV);
    chk("div bus reset", {16'h0000, `PBT_OSC_DIV_RESET}, rd_q);
    $display("test bus reset done");
    stop_test();
  end
endmodule
